// >>> pac_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the approach control block
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte index on the plain register port)
// ----------------------------------------------------------------
`define PAC_OFS_PRELOAD_A 4'h0
`define PAC_OFS_PRELOAD_B 4'h1
`define PAC_OFS_TARGET_C 4'h2
`define PAC_OFS_TARGET_D 4'h3
`define PAC_OFS_EXTENSION 4'h4
`define PAC_OFS_WIDTH_LIMIT 4'h5
`define PAC_OFS_OUTPUT_CODE 4'h6
`define PAC_OFS_CTRL_STATUS 4'h7
`define PAC_OFS_TRIG_CONFIG 4'h8
`define PAC_OFS_SEQ_CTRL 4'h9
`define PAC_OFS_SEQ_PRELOAD1 4'hA
`define PAC_OFS_SEQ_COUNT 4'hB

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PAC_EXT_A8 0
`define PAC_EXT_C8 2
`define PAC_EXT_B8 4
`define PAC_EXT_D8 6
`define PAC_CS_ENABLE 7
`define PAC_CS_MODE 6
`define PAC_CS_TSEL 5
`define PAC_CS_LOCK 4
`define PAC_CS_IVL_HI 3
`define PAC_CS_IVL_LO 2
`define PAC_CS_CDONE 1
`define PAC_CS_DDONE 0
`define PAC_TC_HWSRC 7
`define PAC_TC_CNT_HI 4
`define PAC_TC_CNT_LO 3
`define PAC_TC_STEP_HI 2
`define PAC_TC_STEP_LO 0
`define PAC_SQ_ENABLE 4
`define PAC_SQ_RELOAD_SEL 0

// ----------------------------------------------------------------
// Output state codes, reset values and width limiter timing counts
// ----------------------------------------------------------------
`define PAC_CODE_FORCE_LOW 8'h32
`define PAC_CODE_FORCE_HIGH 8'h33
`define PAC_CODE_ACTIVE_LOW 8'h55
`define PAC_CODE_HIGH_DRIVE_LOW 8'h8D
`define PAC_CODE_ACTIVE_HIGH 8'hAA
`define PAC_RST_BYTE 8'h00
`define PAC_LIMIT_SPAN 9'h100
`define PAC_HALF_CLK_CYCLES 2'h2

`endif

// >>> pac_pkg.sv
// Types shared by the approach control block
// Assumes nothing beyond a SystemVerilog compiler
package pac_pkg;

  // ----------------------------------------------------------------
  // Output drive decoded from the output state code
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PAC_DRV_FLOAT,
    PAC_DRV_LOW,
    PAC_DRV_HIGH,
    PAC_DRV_PULSE_LOW,
    PAC_DRV_PULSE_HIGH,
    PAC_DRV_PULSE_HIGH_IDLE_LOW
  } pac_drive_t;

endpackage

// >>> pac_top.sv
// Pulse output state, width limiter and approach engine control registers
// Assumes the pulse counter, approach engine and sequence logic share ref_clk_i
//
// Overview of operation
// RL1: Code 00110010 forces the pulse output low, 00110011 forces it high.
// RL2: Codes 01010101, 10101010, 10001101 give low, high, high-with-driven-low pulses.
// RL3: Every other output code leaves the pulse output undriven.
// RL4: Secondary pulse output is held low unless the code is 10001101.
// RL5: Pulse width limited to 256 minus limit value half pulse-clock periods.
// RL6: Targets C and D are 9 bits; bit 8 sits at extension bits 2 and 6.
// RL7: Extension holds preload B bit 8 at 4, preload A bit 8 at 0; odd bits zero.
// RL8: Software mode: software owns approach enable; hardware mode: hardware value shown.
// RL9: Approach mode select 0 is software mode, 1 is hardware mode.
// RL10: Mode select rising clears sequence enable and reloads timer from preload 1.
// RL11: In software mode target select 0 approaches C, 1 approaches D.
// RL12: While lock flag is 1, writes to preload A, count and step are ignored.
// RL13: Hardware mode interval status reports 00, 01, 10, 11 for the four intervals.
// RL14: Hardware sets C-done flag; software may clear it, writing 1 is ignored.
// RL15: Hardware sets D-done flag; software may clear it but not set it.
// RL16: Done flags auto-cleared on enable rise, overvoltage trigger or sequence enable rise (here only in hardware mode with overvoltage trigger source).
// RL17: Hardware mode timer starts on overvoltage event (0) or sequence enable rise (1).
// RL18: Sequence enable writes ignored in hardware mode with overvoltage trigger source.
// RL19: Reload select 0 reloads from preload A, 1 from preload B.
// RL20: Updates are synchronous; hardware auto-clear beats a simultaneous software write.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "pac_map.svh"

module pac_top #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Pulse counter and approach engine (same clock)
  input wire logic pulse_active_i,
  input wire logic pulse_start_i,
  input wire logic hw_approach_enable_i,
  input wire logic [1:0] interval_status_i,
  input wire logic modification_lock_flag_i,
  input wire logic c_done_set_i,
  input wire logic d_done_set_i,
  // Overvoltage event from outside the clock domain
  input wire logic overvoltage_event_i,
  // Pulse output pin
  output logic pulse_gen_o,
  output logic pulse_gen_oe_n_o,
  output logic secondary_hold_low_o,
  // To the approach engine and pulse counter
  output logic approach_enable_o,
  output logic [8:0] approach_target_o,
  output logic [8:0] reload_value_o,
  output logic sequence_timer_start_o
);

  if (ADDR_W < 4) begin
    $error("pac_top: ADDR_W must be at least 4");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [8:0] preload_a;
  logic [8:0] preload_b;
  logic [8:0] approach_target_c;
  logic [8:0] approach_target_d;
  logic [7:0] width_limit_value;
  logic [7:0] output_state_code;
  logic approach_enable;
  logic approach_mode_select;
  logic approach_target_select;
  logic c_approach_done_flag;
  logic d_approach_done_flag;
  logic hw_trigger_source_select;
  logic [1:0] trigger_count_field;
  logic [2:0] approach_step_field;
  logic sequence_timer_enable;
  logic reload_select;
  logic [7:0] sequence_timer_preload_1;
  logic [7:0] sequence_timer;
  logic mode_prev;
  logic enable_prev;
  logic seq_enable_prev;

  logic wr_cs;
  logic wr_tc;
  logic wr_sq;
  assign wr_cs = reg_wr_i && reg_addr_i == ADDR_W'(`PAC_OFS_CTRL_STATUS);
  assign wr_tc = reg_wr_i && reg_addr_i == ADDR_W'(`PAC_OFS_TRIG_CONFIG);
  assign wr_sq = reg_wr_i && reg_addr_i == ADDR_W'(`PAC_OFS_SEQ_CTRL);

  // ----------------------------------------------------------------
  // Overvoltage synchroniser and edge
  // ----------------------------------------------------------------
  logic ovp_meta;
  logic ovp_sync;
  logic ovp_prev;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ovp_meta <= 1'b0;
      ovp_sync <= 1'b0;
      ovp_prev <= 1'b0;
    end else begin
      ovp_meta <= overvoltage_event_i;
      ovp_sync <= ovp_meta;
      ovp_prev <= ovp_sync;
    end
  end

  // ----------------------------------------------------------------
  // Event terms
  // ----------------------------------------------------------------
  logic ovp_trigger;
  logic enable_rise;
  logic seq_enable_rise;
  logic mode_rise;
  logic auto_clear;
  assign mode_rise = approach_mode_select && !mode_prev; // RL10
  assign ovp_trigger = approach_mode_select && !hw_trigger_source_select &&
                       ovp_sync && !ovp_prev;
  assign enable_rise = !approach_mode_select && approach_enable && !enable_prev;
  assign seq_enable_rise = sequence_timer_enable && !seq_enable_prev;
  assign auto_clear = enable_rise || ovp_trigger || // RL16
                      (approach_mode_select && !hw_trigger_source_select &&
                       seq_enable_rise);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      mode_prev <= 1'b0;
      enable_prev <= 1'b0;
      seq_enable_prev <= 1'b0;
    end else begin
      mode_prev <= approach_mode_select;
      enable_prev <= approach_enable;
      seq_enable_prev <= sequence_timer_enable;
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Preload and targets come up at zero although the pins would be unknown
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      preload_a <= 9'h000;
      preload_b <= 9'h000;
      approach_target_c <= 9'h000;
      approach_target_d <= 9'h000;
      width_limit_value <= `PAC_RST_BYTE;
      output_state_code <= `PAC_RST_BYTE;
      sequence_timer_preload_1 <= `PAC_RST_BYTE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_W'(`PAC_OFS_PRELOAD_A): begin
          if (!modification_lock_flag_i) begin
            preload_a[7:0] <= reg_wdata_i; // RL12
          end
        end
        ADDR_W'(`PAC_OFS_PRELOAD_B): preload_b[7:0] <= reg_wdata_i;
        ADDR_W'(`PAC_OFS_TARGET_C): approach_target_c[7:0] <= reg_wdata_i;
        ADDR_W'(`PAC_OFS_TARGET_D): approach_target_d[7:0] <= reg_wdata_i;
        ADDR_W'(`PAC_OFS_EXTENSION): begin
          if (!modification_lock_flag_i) begin
            preload_a[8] <= reg_wdata_i[`PAC_EXT_A8]; // RL7 RL12
          end
          preload_b[8] <= reg_wdata_i[`PAC_EXT_B8]; // RL7
          approach_target_c[8] <= reg_wdata_i[`PAC_EXT_C8]; // RL6
          approach_target_d[8] <= reg_wdata_i[`PAC_EXT_D8]; // RL6
        end
        ADDR_W'(`PAC_OFS_WIDTH_LIMIT): width_limit_value <= reg_wdata_i;
        ADDR_W'(`PAC_OFS_OUTPUT_CODE): output_state_code <= reg_wdata_i;
        ADDR_W'(`PAC_OFS_SEQ_PRELOAD1): sequence_timer_preload_1 <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Approach control and status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      approach_mode_select <= 1'b0;
      approach_target_select <= 1'b0;
    end else if (wr_cs) begin
      approach_mode_select <= reg_wdata_i[`PAC_CS_MODE]; // RL9
      approach_target_select <= reg_wdata_i[`PAC_CS_TSEL];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      approach_enable <= 1'b0;
    end else if (approach_mode_select) begin
      approach_enable <= hw_approach_enable_i; // RL8
    end else if (wr_cs) begin
      approach_enable <= reg_wdata_i[`PAC_CS_ENABLE]; // RL8
    end
  end

  // Hardware set beats every clear so a completion is never lost
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      c_approach_done_flag <= 1'b0;
      d_approach_done_flag <= 1'b0;
    end else begin
      if (c_done_set_i) begin
        c_approach_done_flag <= 1'b1; // RL14
      end else if (auto_clear) begin
        c_approach_done_flag <= 1'b0; // RL16 RL20
      end else if (wr_cs && !reg_wdata_i[`PAC_CS_CDONE]) begin
        c_approach_done_flag <= 1'b0; // RL14
      end
      if (d_done_set_i) begin
        d_approach_done_flag <= 1'b1; // RL15
      end else if (auto_clear) begin
        d_approach_done_flag <= 1'b0; // RL16 RL20
      end else if (wr_cs && !reg_wdata_i[`PAC_CS_DDONE]) begin
        d_approach_done_flag <= 1'b0; // RL15
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger configuration
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      hw_trigger_source_select <= 1'b0;
      trigger_count_field <= 2'h0;
      approach_step_field <= 3'h0;
    end else if (wr_tc) begin
      hw_trigger_source_select <= reg_wdata_i[`PAC_TC_HWSRC];
      if (!modification_lock_flag_i) begin
        trigger_count_field <= reg_wdata_i[`PAC_TC_CNT_HI:`PAC_TC_CNT_LO]; // RL12
        approach_step_field <= reg_wdata_i[`PAC_TC_STEP_HI:`PAC_TC_STEP_LO]; // RL12
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence timer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sequence_timer_enable <= 1'b0;
      reload_select <= 1'b0;
    end else begin
      if (mode_rise) begin
        sequence_timer_enable <= 1'b0; // RL10
      end else if (wr_sq && !(approach_mode_select && !hw_trigger_source_select)) begin
        sequence_timer_enable <= reg_wdata_i[`PAC_SQ_ENABLE]; // RL18
      end
      if (wr_sq) begin
        reload_select <= reg_wdata_i[`PAC_SQ_RELOAD_SEL];
      end
    end
  end

  // Counts down once started; the prescaler lives with the sequence logic
  logic timer_start;
  logic timer_run;
  assign timer_start = approach_mode_select && (hw_trigger_source_select ?
                       seq_enable_rise : ovp_trigger); // RL17
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sequence_timer <= `PAC_RST_BYTE;
      timer_run <= 1'b0;
      sequence_timer_start_o <= 1'b0;
    end else begin
      sequence_timer_start_o <= timer_start;
      if (mode_rise) begin
        sequence_timer <= sequence_timer_preload_1; // RL10
        timer_run <= 1'b0;
      end else if (timer_start) begin
        sequence_timer <= sequence_timer_preload_1; // RL17
        timer_run <= 1'b1;
      end else if (timer_run && sequence_timer != 8'h00) begin
        sequence_timer <= sequence_timer - 8'h01;
      end else begin
        timer_run <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Approach target and reload value
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      approach_target_o <= 9'h000;
      reload_value_o <= 9'h000;
      approach_enable_o <= 1'b0;
    end else begin
      approach_enable_o <= approach_enable;
      if (!approach_mode_select) begin
        approach_target_o <= approach_target_select ? approach_target_d :
                             approach_target_c; // RL11
      end else begin
        approach_target_o <= (interval_status_i == 2'h2) ? approach_target_d :
                             approach_target_c;
      end
      reload_value_o <= reload_select ? preload_b : preload_a; // RL19
    end
  end

  // ----------------------------------------------------------------
  // Pulse width limiter
  // ----------------------------------------------------------------
  // One tick per half pulse-clock period, counted up from the limit value to 256
  logic [1:0] half_div;
  logic [8:0] limit_count;
  logic limit_hit;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      half_div <= 2'h0;
      limit_count <= 9'h000;
      limit_hit <= 1'b0;
    end else if (pulse_start_i || !pulse_active_i) begin
      // Start cycle is the first clock of the first half period
      half_div <= `PAC_HALF_CLK_CYCLES - 2'h1;
      limit_count <= {1'b0, width_limit_value};
      limit_hit <= 1'b0;
    end else if (!limit_hit) begin
      if (half_div == `PAC_HALF_CLK_CYCLES - 2'h1) begin
        half_div <= 2'h0;
        limit_count <= limit_count + 9'h001;
        if (limit_count + 9'h001 == `PAC_LIMIT_SPAN) begin
          limit_hit <= 1'b1; // RL5
        end
      end else begin
        half_div <= half_div + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output state decode
  // ----------------------------------------------------------------
  pac_pkg::pac_drive_t drive;
  always_comb begin
    case (output_state_code)
      `PAC_CODE_FORCE_LOW: drive = pac_pkg::PAC_DRV_LOW; // RL1
      `PAC_CODE_FORCE_HIGH: drive = pac_pkg::PAC_DRV_HIGH; // RL1
      `PAC_CODE_ACTIVE_LOW: drive = pac_pkg::PAC_DRV_PULSE_LOW; // RL2
      `PAC_CODE_ACTIVE_HIGH: drive = pac_pkg::PAC_DRV_PULSE_HIGH; // RL2
      `PAC_CODE_HIGH_DRIVE_LOW: drive = pac_pkg::PAC_DRV_PULSE_HIGH_IDLE_LOW; // RL2
      default: drive = pac_pkg::PAC_DRV_FLOAT; // RL3
    endcase
  end

  logic pulse_on;
  assign pulse_on = pulse_active_i && !limit_hit; // RL5
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pulse_gen_o <= 1'b0;
      pulse_gen_oe_n_o <= 1'b1;
      secondary_hold_low_o <= 1'b1;
    end else begin
      secondary_hold_low_o <= drive != pac_pkg::PAC_DRV_PULSE_HIGH_IDLE_LOW; // RL4
      case (drive)
        pac_pkg::PAC_DRV_LOW: begin
          pulse_gen_o <= 1'b0;
          pulse_gen_oe_n_o <= 1'b0;
        end
        pac_pkg::PAC_DRV_HIGH: begin
          pulse_gen_o <= 1'b1;
          pulse_gen_oe_n_o <= 1'b0;
        end
        pac_pkg::PAC_DRV_PULSE_LOW: begin
          pulse_gen_o <= !pulse_on;
          pulse_gen_oe_n_o <= 1'b0;
        end
        pac_pkg::PAC_DRV_PULSE_HIGH, pac_pkg::PAC_DRV_PULSE_HIGH_IDLE_LOW: begin
          pulse_gen_o <= pulse_on;
          pulse_gen_oe_n_o <= 1'b0;
        end
        default: begin
          pulse_gen_o <= 1'b0;
          pulse_gen_oe_n_o <= 1'b1; // RL3
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      ADDR_W'(`PAC_OFS_PRELOAD_A): next_rdata = preload_a[7:0];
      ADDR_W'(`PAC_OFS_PRELOAD_B): next_rdata = preload_b[7:0];
      ADDR_W'(`PAC_OFS_TARGET_C): next_rdata = approach_target_c[7:0];
      ADDR_W'(`PAC_OFS_TARGET_D): next_rdata = approach_target_d[7:0];
      ADDR_W'(`PAC_OFS_EXTENSION): begin
        next_rdata[`PAC_EXT_A8] = preload_a[8]; // RL7
        next_rdata[`PAC_EXT_C8] = approach_target_c[8];
        next_rdata[`PAC_EXT_B8] = preload_b[8];
        next_rdata[`PAC_EXT_D8] = approach_target_d[8];
      end
      ADDR_W'(`PAC_OFS_WIDTH_LIMIT): next_rdata = width_limit_value;
      ADDR_W'(`PAC_OFS_OUTPUT_CODE): next_rdata = output_state_code;
      ADDR_W'(`PAC_OFS_CTRL_STATUS): begin
        next_rdata[`PAC_CS_ENABLE] = approach_enable;
        next_rdata[`PAC_CS_MODE] = approach_mode_select;
        next_rdata[`PAC_CS_TSEL] = approach_target_select;
        next_rdata[`PAC_CS_LOCK] = modification_lock_flag_i;
        if (approach_mode_select) begin
          next_rdata[`PAC_CS_IVL_HI:`PAC_CS_IVL_LO] = interval_status_i; // RL13
        end
        next_rdata[`PAC_CS_CDONE] = c_approach_done_flag;
        next_rdata[`PAC_CS_DDONE] = d_approach_done_flag;
      end
      ADDR_W'(`PAC_OFS_TRIG_CONFIG): begin
        next_rdata[`PAC_TC_HWSRC] = hw_trigger_source_select;
        next_rdata[`PAC_TC_CNT_HI:`PAC_TC_CNT_LO] = trigger_count_field;
        next_rdata[`PAC_TC_STEP_HI:`PAC_TC_STEP_LO] = approach_step_field;
      end
      ADDR_W'(`PAC_OFS_SEQ_CTRL): begin
        next_rdata[`PAC_SQ_ENABLE] = sequence_timer_enable;
        next_rdata[`PAC_SQ_RELOAD_SEL] = reload_select;
      end
      ADDR_W'(`PAC_OFS_SEQ_PRELOAD1): next_rdata = sequence_timer_preload_1;
      ADDR_W'(`PAC_OFS_SEQ_COUNT): next_rdata = sequence_timer;
      default: next_rdata = 8'h00;
    endcase
  end

  // Data stand for exactly one cycle, zero otherwise
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
    end
  end

endmodule

// >>> pac_chk.sv
// Port checker for the approach control block
// Assumes binding onto pac_top, one clock, synchronous active-low reset
`timescale 1ns/1ns
module pac_chk #(
  parameter int ADDR_W = 4
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic c_done_set_i,
  input wire logic pulse_gen_o,
  input wire logic pulse_gen_oe_n_o,
  input wire logic secondary_hold_low_o,
  input wire logic sequence_timer_start_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic cw;
  // Code write lands one edge, pin follows one edge later
  assign cw = reg_wr_i && reg_addr_i == 6;
  a_force_low:
    assert property (cw && reg_wdata_i == 8'h32 |-> ##2 !pulse_gen_o && !pulse_gen_oe_n_o)
    else $error("force low code not driven low");
  a_force_high:
    assert property (cw && reg_wdata_i == 8'h33 |-> ##2 pulse_gen_o && !pulse_gen_oe_n_o)
    else $error("force high code not driven high");
  a_float_other:
    assert property (cw && !(reg_wdata_i inside {8'h32, 8'h33, 8'h55, 8'hAA, 8'h8D})
      |-> ##2 pulse_gen_oe_n_o) else $error("undefined code still drives pin");
  a_second_low:
    assert property (cw && reg_wdata_i != 8'h8D |-> ##2 secondary_hold_low_o)
    else $error("secondary output not held low");
  a_second_free:
    assert property (cw && reg_wdata_i == 8'h8D |-> ##2 !secondary_hold_low_o)
    else $error("secondary output held low on 8D");
  a_rdata_idle:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_zero:
    assert property (reg_rd_i && reg_addr_i > 11 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_ext_odd_zero:
    assert property (reg_rd_i && reg_addr_i == 4 |=> (reg_rdata_o & 8'hAA) == 8'h00)
    else $error("extension odd bits not zero");
  a_start_pulse:
    assert property (sequence_timer_start_o |=> !sequence_timer_start_o)
    else $error("timer start longer than one cycle");
  c_pulse_code: cover property (cw && reg_wdata_i == 8'hAA);
  c_c_done: cover property (c_done_set_i);
  c_timer_start: cover property (sequence_timer_start_o);
endmodule

bind pac_top pac_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// >>> tb_top.sv
// Self-checking bench for the approach control block
// Assumes pac_top and the bind in pac_chk.sv are compiled first
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and tasks
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, act = 1'b0, start = 1'b0;
  logic hw_en = 1'b0, lock = 1'b0, cset = 1'b0, dset = 1'b0, ovp = 1'b0;
  logic [1:0] ivl = 2'b00;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic pin, oe_n, sec, en, tstart;
  logic [8:0] tgt, rld;
  logic [7:0] codes [7] = '{8'h32, 8'h33, 8'h55, 8'hAA, 8'h8D, 8'h00, 8'hFF};
  int n_errors = 0, total_checks = 0;
  always #5 ref_clk = ~ref_clk;
  pac_top DUT (.ref_clk_i(ref_clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pulse_active_i(act),
    .pulse_start_i(start), .hw_approach_enable_i(hw_en), .interval_status_i(ivl),
    .modification_lock_flag_i(lock), .c_done_set_i(cset), .d_done_set_i(dset),
    .overvoltage_event_i(ovp), .pulse_gen_o(pin), .pulse_gen_oe_n_o(oe_n),
    .secondary_hold_low_o(sec), .approach_enable_o(en), .approach_target_o(tgt),
    .reload_value_o(rld), .sequence_timer_start_o(tstart));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Strobe released at the next edge; a later call waits one more edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask
  task automatic pulse_done(input logic c);
    @(posedge ref_clk);
    cset <= c;
    dset <= !c;
    @(posedge ref_clk);
    cset <= 1'b0;
    dset <= 1'b0;
  endtask
  task automatic wait_start(input string n);
    int k;
    k = 0;
    while (tstart !== 1'b1 && k < 20) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    `CHK(n, 1'b1, tstart)
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    $display("watchdog expired");
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) rd_reg("reset", i[3:0], 8'h00);
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("sec", 1'b1, sec)
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      wr_reg(4'h6, codes[i]);
      tick(2);
      `CHK("oe_n", !(codes[i] inside {8'h32, 8'h33, 8'h55, 8'hAA, 8'h8D}), oe_n)
      `CHK("sec", codes[i] != 8'h8D, sec)
      if (i < 5) `CHK("pin", codes[i] == 8'h33 || codes[i] == 8'h55, pin)
      rd_reg("code", 4'h6, codes[i]);
    end
    // Limit F0 gives 16 half-rate periods, 32 clocks
    wr_reg(4'h6, 8'hAA);
    wr_reg(4'h5, 8'hF0);
    @(posedge ref_clk);
    act <= 1'b1;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    tick(4);
    `CHK("pulse", 1'b1, pin)
    tick(27);
    `CHK("last", 1'b1, pin)
    tick(1);
    `CHK("cut", 1'b0, pin)
    act <= 1'b0;
    $display("output test done");
    wr_reg(4'h4, 8'hFF);
    rd_reg("ext", 4'h4, 8'h55);
    wr_reg(4'h2, 8'h34);
    wr_reg(4'h3, 8'h56);
    wr_reg(4'h0, 8'h12);
    wr_reg(4'h1, 8'h9A);
    wr_reg(4'h7, 8'h80);
    tick(2);
    `CHK("tgt c", 9'h134, tgt)
    `CHK("en", 1'b1, en)
    `CHK("rld a", 9'h112, rld)
    wr_reg(4'h7, 8'hA0);
    wr_reg(4'h9, 8'h01);
    tick(2);
    `CHK("tgt d", 9'h156, tgt)
    `CHK("rld b", 9'h19A, rld)
    lock <= 1'b1;
    wr_reg(4'h0, 8'h77);
    wr_reg(4'h8, 8'h1F);
    rd_reg("lock a", 4'h0, 8'h12);
    rd_reg("lock cfg", 4'h8, 8'h00);
    rd_reg("lock bit", 4'h7, 8'hB0);
    lock <= 1'b0;
    wr_reg(4'h8, 8'h1F);
    rd_reg("cfg", 4'h8, 8'h1F);
    $display("target test done");
    pulse_done(1'b1);
    rd_reg("c set", 4'h7, 8'hA2);
    wr_reg(4'h7, 8'hA0);
    rd_reg("c clr", 4'h7, 8'hA0);
    wr_reg(4'h7, 8'hA3);
    rd_reg("no set", 4'h7, 8'hA0);
    pulse_done(1'b0);
    wr_reg(4'h7, 8'h21);
    rd_reg("d set", 4'h7, 8'h21);
    wr_reg(4'h7, 8'hA1);
    rd_reg("en clr", 4'h7, 8'hA0);
    $display("flag test done");
    wr_reg(4'h9, 8'h11);
    wr_reg(4'hA, 8'h05);
    hw_en <= 1'b1;
    ivl <= 2'b10;
    wr_reg(4'h7, 8'h40);
    rd_reg("hw ctl", 4'h7, 8'hC8);
    rd_reg("ton clr", 4'h9, 8'h01);
    rd_reg("reload", 4'hB, 8'h05);
    `CHK("hw tgt", 9'h156, tgt)
    wr_reg(4'h9, 8'h11);
    rd_reg("ton lock", 4'h9, 8'h01);
    for (int i = 0; i < 4; i++) begin
      ivl <= i[1:0];
      rd_reg("ivl", 4'h7, {4'hC, i[1:0], 2'b00});
    end
    hw_en <= 1'b0;
    wr_reg(4'h7, 8'hC0);
    rd_reg("sw ign", 4'h7, 8'h4C);
    pulse_done(1'b1);
    ovp <= 1'b1;
    wait_start("ovp start");
    rd_reg("ovp clr", 4'h7, 8'h4C);
    wr_reg(4'h8, 8'h9F);
    wr_reg(4'h9, 8'h11);
    wait_start("ton start");
    rd_reg("ton ok", 4'h9, 8'h11);
    $display("hardware test done");
    give_verdict();
  end
endmodule
